//--- rtl/i2c_port_regs.vh
`ifndef I2C_PORT_REGS_VH
`define I2C_PORT_REGS_VH
// Status and control bit positions
`define STAT_BUF_FULL_BIT     0
`define CTRL_OVF_BIT          6
`define CTRL_RELEASE_BIT      4
`define CTRL2_STRETCH_BIT     0
`define FLAG_EVENT_BIT        3
// Reload field width (bits 6:0)
`define RELOAD_W              7
`define RELOAD_ZERO           7'h00
// Byte and bit counts
`define BYTE_W                8
`define BIT_CNT_W             4
`define BIT_NINTH             4'h8
`define BIT_LAST_DATA         4'h7
`define BIT_ZERO              4'h0
// Fifo sizing
`define FIFO_WIDTH            8
`define FIFO_DEPTH            16
`define FIFO_AW               4
`endif

//--- rtl/byte_fifo.v
`timescale 1ns/100ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  wire            load;

  // Full and empty from the occupancy count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign load     = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign pop      = load;

  // Storage; read data leaves through a register
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers, count and output stage
  always @(posedge clk) begin
    if (rst) begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        out_data  <= mem[rd_q];
        rd_q      <= rd_q + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

//--- rtl/i2c_port.v
`timescale 1ns/100ps
`include "i2c_port_regs.vh"
module i2c_port #(
  parameter [6:0] OWN_ADDR = 7'h2a
) (
  input  wire                 clk,
  input  wire                 rst,
  // Open-drain pins, enable low while pulling low
  input  wire                 scl_in,
  output wire                 scl_out,
  output wire                 scl_oe_n,
  input  wire                 sda_in,
  output wire                 sda_out,
  output wire                 sda_oe_n,
  // Control bits
  input  wire [`RELOAD_W-1:0] rate_reload,
  input  wire                 stretch_enable_bit,
  input  wire                 clock_release_set,
  input  wire                 start_req,
  input  wire                 event_flag_clr,
  input  wire                 overflow_clr,
  input  wire                 collision_clr,
  // Transmit byte written by software
  input  wire [`BYTE_W-1:0]   tx_data,
  input  wire                 tx_write,
  // Received bytes towards software
  output wire [`BYTE_W-1:0]   rx_data,
  output wire                 rx_valid,
  input  wire                 rx_ready,
  // Status
  output reg  [`BYTE_W-1:0]   serial_buffer_register,
  output reg                  rw_status,
  output reg                  buffer_full_flag,
  output reg                  receive_overflow_flag,
  output reg                  serial_event_flag,
  output reg                  bus_collision_flag,
  output reg                  clock_release_bit,
  output reg                  start_busy,
  output reg                  start_done
);
  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg       scl_q;
  reg       sda_q;
  wire      scl_rise;
  wire      scl_fall;
  wire      start_seen;
  wire      stop_seen;

  // Three stages; level changes only when the last two agree
  always @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
    end
  end

  wire scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
  wire sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
  assign scl_rise   = scl_new && !scl_q;
  assign scl_fall   = !scl_new && scl_q;
  assign start_seen = scl_q && scl_new && sda_q && !sda_new;
  assign stop_seen  = scl_q && scl_new && !sda_q && sda_new;

  //--------------------------------------------------------------------
  // Received byte fifo
  //--------------------------------------------------------------------
  reg  [`BYTE_W-1:0] fifo_in_q;
  reg                fifo_push_q;
  wire               fifo_in_ready;

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (fifo_in_q),
    .in_valid  (fifo_push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  //--------------------------------------------------------------------
  // Slave engine
  //--------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_RX   = 3'h2;
  localparam [2:0] S_TX   = 3'h3;
  localparam [2:0] S_TACK = 3'h4;

  reg [2:0]             state_q;
  reg [`BYTE_W-1:0]     transfer_shift_register;
  reg [`BIT_CNT_W-1:0]  bit_q;
  reg                   sda_pull_q;
  reg                   scl_hold_q;
  reg                   ack_byte_q;
  wire                  overflow_now;

  assign overflow_now = buffer_full_flag || receive_overflow_flag;

  // Byte engine, one step per synchronised clock edge
  always @(posedge clk) begin
    if (rst) begin
      state_q                 <= S_IDLE;
      transfer_shift_register <= 8'h00;
      bit_q                   <= `BIT_ZERO;
      sda_pull_q              <= 1'b0;
      scl_hold_q              <= 1'b0;
      ack_byte_q              <= 1'b0;
      serial_buffer_register  <= 8'h00;
      rw_status               <= 1'b0;
      buffer_full_flag        <= 1'b0;
      receive_overflow_flag   <= 1'b0;
      serial_event_flag       <= 1'b0;
      clock_release_bit       <= 1'b1;
      fifo_in_q               <= 8'h00;
      fifo_push_q             <= 1'b0;
    end else begin
      fifo_push_q <= 1'b0;
      // Software clears lose to a same-cycle hardware set below
      if (event_flag_clr) begin
        serial_event_flag <= 1'b0;
      end
      if (overflow_clr) begin
        receive_overflow_flag <= 1'b0;
      end
      if (rx_valid && rx_ready) begin
        buffer_full_flag <= 1'b0;
      end
      if (tx_write) begin
        serial_buffer_register  <= tx_data;
        transfer_shift_register <= tx_data;
      end
      if (clock_release_set) begin
        clock_release_bit <= 1'b1;
        scl_hold_q        <= 1'b0;
      end
      if (stop_seen) begin
        state_q    <= S_IDLE;
        sda_pull_q <= 1'b0;
        ack_byte_q <= 1'b0;
      end else if (start_seen) begin
        state_q    <= S_ADDR;
        bit_q      <= `BIT_ZERO;
        sda_pull_q <= 1'b0;
        ack_byte_q <= 1'b0; // Refused address must not leak into next frame
      end else begin
        case (state_q)
          S_ADDR, S_RX: begin
            if (scl_rise && bit_q <= `BIT_LAST_DATA) begin
              transfer_shift_register <= {transfer_shift_register[6:0], sda_new};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == `BIT_NINTH && !ack_byte_q) begin
              // End of eighth bit: decide acknowledge
              ack_byte_q <= 1'b1;
              if (state_q == S_ADDR) begin
                if (transfer_shift_register[7:1] != OWN_ADDR) begin
                  state_q <= S_IDLE;
                end else if (overflow_now) begin
                  receive_overflow_flag <= 1'b1;
                  state_q               <= S_IDLE;
                end else begin
                  rw_status              <= transfer_shift_register[0];
                  serial_buffer_register <= transfer_shift_register;
                  sda_pull_q             <= 1'b1;
                end
              end else if (overflow_now || !fifo_in_ready) begin
                receive_overflow_flag <= 1'b1; // No ack, byte dropped
              end else begin
                serial_buffer_register <= transfer_shift_register;
                buffer_full_flag       <= 1'b1;
                fifo_in_q              <= transfer_shift_register;
                fifo_push_q            <= 1'b1;
                sda_pull_q             <= 1'b1;
                serial_event_flag      <= 1'b1;
              end
            end else if (scl_fall && ack_byte_q) begin
              // Ninth clock done: release data, maybe stretch
              ack_byte_q <= 1'b0;
              sda_pull_q <= 1'b0;
              bit_q      <= `BIT_ZERO;
              if (state_q == S_ADDR && rw_status) begin
                state_q           <= S_TX;
                scl_hold_q        <= 1'b1;
                clock_release_bit <= 1'b0;
                serial_event_flag <= 1'b1;
              end else begin
                state_q <= S_RX;
                if (stretch_enable_bit && state_q == S_RX) begin
                  scl_hold_q        <= 1'b1;
                  clock_release_bit <= 1'b0;
                end
              end
            end
          end
          S_TX: begin
            // Drive bits while clock low, hold them through high time
            if (bit_q == `BIT_ZERO && !scl_hold_q && !scl_q && !sda_pull_q && !ack_byte_q) begin
              sda_pull_q              <= !transfer_shift_register[7];
              transfer_shift_register <= {transfer_shift_register[6:0], 1'b0};
              ack_byte_q              <= 1'b1;
            end else if (scl_fall && ack_byte_q) begin
              if (bit_q == `BIT_LAST_DATA) begin
                sda_pull_q <= 1'b0;
                state_q    <= S_TACK;
                ack_byte_q <= 1'b0;
              end else begin
                sda_pull_q              <= !transfer_shift_register[7];
                transfer_shift_register <= {transfer_shift_register[6:0], 1'b0};
              end
              bit_q <= bit_q + 4'h1;
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              if (sda_new) begin
                state_q <= S_IDLE;
              end else begin
                ack_byte_q <= 1'b1;
              end
            end else if (scl_fall && ack_byte_q) begin
              serial_event_flag <= 1'b1;
              scl_hold_q        <= 1'b1;
              clock_release_bit <= 1'b0;
              ack_byte_q        <= 1'b0;
              bit_q             <= `BIT_ZERO;
              state_q           <= S_TX;
            end
          end
          default: begin
            state_q    <= S_IDLE;
            sda_pull_q <= 1'b0;
            scl_hold_q <= 1'b0;
          end
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Start condition generator with collision check
  //--------------------------------------------------------------------
  localparam [1:0] M_IDLE  = 2'h0;
  localparam [1:0] M_FIRST = 2'h1;
  localparam [1:0] M_SECND = 2'h2;

  reg [1:0]           mstate_q;
  reg [`RELOAD_W-1:0] rate_counter;
  reg                 m_sda_q;
  reg                 m_scl_q;

  // Competing starts after the request are not flagged; the first count just ends early
  always @(posedge clk) begin
    if (rst) begin
      mstate_q           <= M_IDLE;
      rate_counter       <= `RELOAD_ZERO;
      m_sda_q            <= 1'b0;
      m_scl_q            <= 1'b0;
      bus_collision_flag <= 1'b0;
      start_busy         <= 1'b0;
      start_done         <= 1'b0;
    end else begin
      start_done <= 1'b0;
      if (collision_clr) begin
        bus_collision_flag <= 1'b0;
      end
      case (mstate_q)
        M_IDLE: begin
          if (start_req) begin
            if (!sda_q || !scl_q) begin
              bus_collision_flag <= 1'b1;
            end else begin
              rate_counter <= rate_reload;
              mstate_q     <= M_FIRST;
              start_busy   <= 1'b1;
            end
          end
        end
        M_FIRST: begin
          if (!scl_q) begin
            bus_collision_flag <= 1'b1;
            mstate_q           <= M_IDLE;
            start_busy         <= 1'b0;
            m_sda_q            <= 1'b0;
          end else if (!sda_q || rate_counter == `RELOAD_ZERO) begin
            m_sda_q      <= 1'b1;
            rate_counter <= rate_reload;
            mstate_q     <= M_SECND;
          end else begin
            rate_counter <= rate_counter - 7'h01;
          end
        end
        M_SECND: begin
          // Clock low here is tolerated
          if (rate_counter == `RELOAD_ZERO) begin
            m_scl_q    <= 1'b1;
            mstate_q   <= M_IDLE;
            start_busy <= 1'b0;
            start_done <= 1'b1;
          end else begin
            rate_counter <= rate_counter - 7'h01;
          end
        end
        default: begin
          mstate_q <= M_IDLE;
        end
      endcase
      if (collision_clr && !start_busy) begin
        m_sda_q <= 1'b0;
        m_scl_q <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Open-drain pins: only pull low or release
  //--------------------------------------------------------------------
  assign sda_out  = 1'b0;
  assign scl_out  = 1'b0;
  assign sda_oe_n = !(sda_pull_q || m_sda_q);
  assign scl_oe_n = !(scl_hold_q || m_scl_q);
endmodule

//--- dv/i2c_port_checker.sv
`timescale 1ns/100ps
// ------------------------------
// Port checker
// ------------------------------
module i2c_port_checker (
  input wire       clk,
  input wire       rst,
  input wire       scl_out,
  input wire       sda_out,
  input wire       scl_oe_n,
  input wire       sda_oe_n,
  input wire       clock_release_set,
  input wire       start_req,
  input wire [7:0] rx_data,
  input wire       rx_valid,
  input wire       rx_ready,
  input wire       clock_release_bit,
  input wire       bus_collision_flag,
  input wire       start_busy,
  input wire       start_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pins may only pull low, never drive high
  property p_pull_only; !scl_out && !sda_out; endproperty
  a_pull_only: assert property (p_pull_only) else $error("pin data high");
  property p_release; clock_release_set |=> clock_release_bit; endproperty
  a_release: assert property (p_release) else $error("release bit not set");
  // Cleared release bit means the clock is being held
  property p_hold; !clock_release_bit ##1 !clock_release_bit |-> !scl_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_busy_cause; $rose(start_busy) |-> $past(start_req); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("start without request");
  // Two counts of at most 128 cycles each, plus margin
  property p_busy_bound; $rose(start_busy) |-> ##[1:600] !start_busy; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("start never ends");
  property p_done_pins; start_done |-> ##[0:2] (!sda_oe_n && !scl_oe_n); endproperty
  a_done_pins: assert property (p_done_pins) else $error("start end pins wrong");
  property p_scl_after_sda;
    $fell(scl_oe_n) && (start_busy || start_done) |-> !sda_oe_n;
  endproperty
  a_scl_after_sda: assert property (p_scl_after_sda) else $error("clock before data");
  property p_coll_idle; $rose(bus_collision_flag) |-> ##[0:2] !start_busy; endproperty
  a_coll_idle: assert property (p_coll_idle) else $error("collision not idle");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx data dropped");
  c_done: cover property (start_done);
  c_coll: cover property ($rose(bus_collision_flag));
  c_pop: cover property (rx_valid && rx_ready);
endmodule

bind i2c_port i2c_port_checker u_chk (.clk, .rst, .scl_out, .sda_out, .scl_oe_n, .sda_oe_n,
  .clock_release_set, .start_req, .rx_data, .rx_valid, .rx_ready, .clock_release_bit,
  .bus_collision_flag, .start_busy, .start_done);

//--- dv/i2c_master_model.sv
`timescale 1ns/100ps
// ------------------------------
// External bus master
// ------------------------------
module i2c_master_model (
  input  wire scl,
  input  wire sda,
  output reg  scl_m,
  output reg  sda_m
);
  integer k;
  // Released lines read high through the pull-up
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // Slave may stretch; bounded so a stuck clock cannot hang
  task wait_hi;
    for (k = 0; k < 400 && !scl; k = k + 1) #25;
  endtask
  task start;
    begin
      sda_m = 1'b0;
      #100;
      scl_m = 1'b0;
    end
  endtask
  // Data changes only while the clock is low
  task bit_io(input b, output r);
    begin
      #50;
      sda_m = b;
      #50;
      scl_m = 1'b1;
      wait_hi;
      #100;
      r = sda;
      scl_m = 1'b0;
    end
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task xfer(input [7:0] b, input ab, output [7:0] r, output as);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(b[i], r[i]);
      bit_io(ab, as);
    end
  endtask
  task stop;
    begin
      #50;
      sda_m = 1'b0;
      #50;
      scl_m = 1'b1;
      wait_hi;
      #100;
      sda_m = 1'b1;
      #200;
    end
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/100ps
// ------------------------------
// Testbench
// ------------------------------
module tb_top;
  reg        clk, rst, stretch_enable_bit, ack;
  reg  [6:0] pl, rate_reload;
  reg  [7:0] tx_data, r;
  wire       scl_oe_n, sda_oe_n, scl_m, sda_m, rx_valid, rw_status, buffer_full_flag;
  wire       serial_event_flag, bus_collision_flag, clock_release_bit, start_busy;
  wire       receive_overflow_flag;
  wire [7:0] rx_data, serial_buffer_register;
  integer    n_fail, check_count, cyc, k, j;
  // Open-drain wires: anyone pulling low wins
  wire       scl = scl_m & scl_oe_n;
  wire       sda = sda_m & sda_oe_n;
  i2c_port uut (.clk, .rst, .scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(),
    .sda_oe_n, .rate_reload, .stretch_enable_bit, .clock_release_set(pl[0]),
    .start_req(pl[1]), .event_flag_clr(pl[2]), .overflow_clr(pl[3]), .collision_clr(pl[4]),
    .tx_data, .tx_write(pl[5]), .rx_data, .rx_valid, .rx_ready(pl[6]),
    .serial_buffer_register, .rw_status, .buffer_full_flag, .receive_overflow_flag,
    .serial_event_flag, .bus_collision_flag, .clock_release_bit, .start_busy, .start_done());
  i2c_master_model m (.scl, .sda, .scl_m, .sda_m);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  task wait_cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // One-cycle strobes: bit0 release, 1 start, 2/3/4 clears, 5 tx write, 6 pop
  task pulse(input [6:0] s);
    begin
      @(posedge clk) pl <= s;
      @(posedge clk) pl <= 7'h00;
      #1;
    end
  endtask
  task do_reset;
    begin
      @(posedge clk) rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(4);
    end
  endtask
  task drain;
    begin
      for (k = 0; k < 20 && rx_valid; k = k + 1) pulse(7'h40);
      pulse(7'h0d);
    end
  endtask
  task send(input [7:0] d);
    begin
      @(posedge clk) tx_data <= d;
      pl <= 7'h20;
      pulse(7'h01);
    end
  endtask
  task t_read;
    begin
      m.start;
      m.xfer(8'h55, 1'b1, r, ack);
      wait_cyc(8);
      chk(ack, 0);
      chk(rw_status, 1);
      chk(serial_buffer_register, 8'h55);
      chk(scl_oe_n, 0);
      chk(serial_event_flag, 1);
      pulse(7'h04);
      send(8'h3c);
      m.xfer(8'hff, 1'b0, r, ack);
      wait_cyc(8);
      chk(r, 8'h3c);
      chk(serial_event_flag, 1);
      chk(scl_oe_n, 0);
      pulse(7'h04);
      send(8'hc3);
      m.xfer(8'hff, 1'b1, r, ack);
      wait_cyc(8);
      chk(r, 8'hc3);
      chk(sda_oe_n, 1);
      chk(scl_oe_n, 1);
      m.stop;
      $display("read test done");
    end
  endtask
  task t_write;
    begin
      drain;
      @(posedge clk) stretch_enable_bit <= 1'b1;
      m.start;
      m.xfer(8'h54, 1'b1, r, ack);
      wait_cyc(8);
      chk(ack, 0);
      chk(rw_status, 0);
      chk(serial_buffer_register, 8'h54);
      drain;
      m.xfer(8'ha5, 1'b1, r, ack);
      wait_cyc(8);
      chk(ack, 0);
      chk(serial_event_flag, 1);
      chk(scl_oe_n, 0);
      chk(rx_data, 8'ha5);
      chk(buffer_full_flag, 1);
      pulse(7'h05);
      m.stop;
      m.start;
      m.xfer(8'h54, 1'b1, r, ack);
      chk(ack, 1);
      chk(receive_overflow_flag, 1);
      m.stop;
      drain;
      chk(receive_overflow_flag, 0);
      chk(buffer_full_flag, 0);
      $display("write test done");
    end
  endtask
  task t_start_ok;
    begin
      @(posedge clk) rate_reload <= 7'h10;
      pulse(7'h02);
      for (k = 0; k < 40 && sda_oe_n; k = k + 1) wait_cyc(1);
      chk(k >= 16 && k <= 19, 1);
      for (k = 0; k < 40 && scl_oe_n; k = k + 1) wait_cyc(1);
      chk(k >= 16 && k <= 19, 1);
      chk(bus_collision_flag, 0);
      do_reset;
      $display("start test done");
    end
  endtask
  task t_coll;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        m.scl_m = (j == 1);
        m.sda_m = (j != 1);
        wait_cyc(6);
        pulse(7'h02);
        if (j == 2) begin
          wait_cyc(6);
          m.scl_m = 1'b0;
        end
        wait_cyc(8);
        chk(bus_collision_flag, 1);
        chk(start_busy, 0);
        chk(sda_oe_n, 1);
        m.scl_m = 1'b1;
        m.sda_m = 1'b1;
        wait_cyc(6);
        pulse(7'h10);
      end
      $display("collision test done");
    end
  endtask
  task t_early;
    begin
      @(posedge clk) rate_reload <= 7'h28;
      pulse(7'h02);
      wait_cyc(4);
      m.sda_m = 1'b0;
      for (k = 0; k < 40 && sda_oe_n; k = k + 1) wait_cyc(1);
      chk(k < 10, 1);
      wait_cyc(10);
      m.scl_m = 1'b0;
      for (k = 0; k < 100 && start_busy; k = k + 1) wait_cyc(1);
      chk(bus_collision_flag, 0);
      chk(scl_oe_n, 0);
      m.scl_m = 1'b1;
      m.sda_m = 1'b1;
      do_reset;
      $display("early start test done");
    end
  endtask
  initial begin
    rst = 1'b1;
    pl = 7'h00;
    stretch_enable_bit = 1'b0;
    rate_reload = 7'h10;
    tx_data = 8'h00;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    do_reset;
    t_read;
    t_write;
    t_start_ok;
    t_coll;
    t_early;
    test_done;
  end
endmodule
